// [hdl/gdl_pkg.sv]
/*
 Shared constants, state encodings and carrier structs for the gate drive
 lockout block. Assumes one 50 MHz clock and an active high async reset.
*/
package gdl_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int GDL_NPH = 3;
   localparam int GDL_NEV = 4;
   localparam logic [3:0] GDL_SPI_BITS = 4'h8;
   localparam logic [3:0] GDL_CNT_MAX = 4'hF;

   // ----------------------------------------------------------------
   // Command encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] GDL_OP_MASK = 3'h1;
   localparam logic [3:0] GDL_OP_MODE = 4'h4;
   localparam logic [7:0] GDL_STATUS_QUERY_CMD_LOW = 8'h00;
   localparam logic [7:0] GDL_STATUS_QUERY_CMD_HIGH = 8'h01;
   localparam logic [7:0] GDL_STATUS_QUERY_CMD_DT = 8'h02;
   localparam logic [7:0] GDL_CLEAR_IRQ_CMD_LOW = 8'h60;
   localparam logic [7:0] GDL_CLEAR_IRQ_CMD_HIGH = 8'h61;
   localparam logic [7:0] GDL_DT_ZERO_CMD = 8'h80;
   localparam logic [7:0] GDL_DT_CAL_CMD = 8'h81;
   localparam logic [3:0] GDL_CLR_LOW_BITS = 4'h3;
   localparam logic [3:0] GDL_CLR_HIGH_BITS = 4'hC;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] GDL_MASK_RST = 4'h0;
   localparam logic [2:0] GDL_MODE_RST = 3'h0;
   localparam logic [7:0] GDL_DT_RST = 8'h00;

   typedef enum logic [1:0] {
      GDL_PH_LOCKED = 2'b00,
      GDL_PH_ARMED = 2'b01,
      GDL_PH_PULSE = 2'b10,
      GDL_PH_RUN = 2'b11
   } gdl_ph_e;

   typedef struct packed {
      logic [GDL_NPH-1:0] ls;
      logic [GDL_NPH-1:0] hs_n;
   } gdl_phase_in_s;

   typedef struct packed {
      logic en1;
      logic en2;
      logic run_pin;
      logic pump;
      logic shut;
      logic [GDL_NEV-1:0] ev;
      logic sck;
      logic cs_n;
      logic mosi;
      gdl_phase_in_s ph;
   } gdl_pins_s;

   localparam gdl_pins_s GDL_PINS_RST = '{
      en1: 1'b0, en2: 1'b0, run_pin: 1'b0, pump: 1'b0, shut: 1'b0,
      ev: 4'h0, sck: 1'b0, cs_n: 1'b1, mosi: 1'b0,
      ph: '{ls: 3'h0, hs_n: 3'h7}};

   typedef struct packed {
      gdl_ph_e [GDL_NPH-1:0] ph;
      logic [GDL_NEV-1:0] flags;
      logic [GDL_NEV-1:0] mask;
      logic [2:0] mode;
      logic locked;
      logic [7:0] deadtime;
      logic powered;
      logic pump_on;
      logic irq;
      logic [GDL_NPH-1:0] ls_prev;
      logic [GDL_NPH-1:0] hs_prev;
      logic [GDL_NPH-1:0] hs_gate;
      logic [GDL_NPH-1:0] ls_gate;
      logic [GDL_NPH-1:0] hs_short;
   } gdl_core_s;

   typedef struct packed {
      logic sck_prev;
      logic cs_prev;
      logic [3:0] cnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic [7:0] pend;
      logic [7:0] cmd;
      logic valid;
      logic miso;
   } gdl_spi_s;

endpackage : gdl_pkg

// [hdl/gdl_sync.sv]
/*
 Three stage pin synchroniser with agreement filter.
 Assumes asynchronous pins; output changes once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module gdl_sync import gdl_pkg::*; #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] raw_in,
   output logic [W-1:0] filt_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } gdl_sync_s;

   gdl_sync_s s_reg;
   gdl_sync_s s_next;

   // ----------------------------------------------------------------
   // Stages; first stage only feeds the second
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.s1 = raw_in;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      s_next.q = (s_reg.s2 & s_reg.s3) |
                 (~(s_reg.s2 ^ s_reg.s3) & s_reg.s3) |
                 ((s_reg.s2 ^ s_reg.s3) & s_reg.q);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
      end else begin
         s_reg <= s_next;
      end
   end

   assign filt_out = s_reg.q;

endmodule : gdl_sync
`default_nettype wire

// [hdl/gdl_spi_slave.sv]
/*
 Byte wide command slave, clock idle low, sample on rising edge.
 Assumes already synchronised pins; answers one message late.
*/
`timescale 1ns/1ps
`default_nettype none
module gdl_spi_slave import gdl_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic [7:0] rsp,
   output logic [7:0] cmd,
   output logic cmd_valid,
   output logic miso,
   output logic miso_oe
);

   gdl_spi_s r_reg;
   gdl_spi_s r_next;

   // ----------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.valid = 1'b0;
      r_next.sck_prev = sck;
      r_next.cs_prev = cs_n;
      if (r_reg.valid) begin
         r_next.pend = rsp;
      end
      if (!cs_n && r_reg.cs_prev) begin
         r_next.tx = r_reg.pend;
         r_next.miso = r_reg.pend[7];
         r_next.cnt = 4'h0;
      end else if (!cs_n) begin
         if (sck && !r_reg.sck_prev) begin
            r_next.rx = {r_reg.rx[6:0], mosi};
            if (r_reg.cnt != GDL_CNT_MAX) begin
               r_next.cnt = r_reg.cnt + 4'h1;
            end
         end
         if (!sck && r_reg.sck_prev) begin
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.miso = r_reg.tx[6];
         end
      end else if (!r_reg.cs_prev && r_reg.cnt == GDL_SPI_BITS) begin
         // Frames of any other length are dropped
         r_next.cmd = r_reg.rx;
         r_next.valid = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '{cs_prev: 1'b1, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign cmd = r_reg.cmd;
   assign cmd_valid = r_reg.valid;
   assign miso = r_reg.miso;
   assign miso_oe = ~cs_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   resp_next_msg_a: assert property (
      (!cs_n && r_reg.cs_prev) |=> (miso == $past(r_reg.pend[7])))
      else $error("answer not taken from previous message");

endmodule : gdl_spi_slave
`default_nettype wire

// [hdl/gdl_core.sv]
/*
 Gate drive lockout core: per phase lock and re-arm sequencing, standby
 and shutdown handling, command decode, status flags and interrupt.
 Assumes all pins asynchronous to clk; analog drive stages outside.
*/
// Contract
// - Standby or shutdown forces gates low and locks high side.
// - Low side outputs enabled only when both enables high.
// - High side pulse on all phases gives high side recirculation.
// - After high side toggle, gate shorted to source, FET off.
// - Phase inputs edge sensitive; low side rise re-arms high side.
// - High side edge not after low side toggle keeps lockout.
// - Merged high and low inputs per phase are accepted.
// - Releasing reset powers up; charge pump starts if configured.
// - Mask commands 0010xxxx or 0011xxxx set mask from low nibble.
// - Mode command with lock bit applies, then blocks mode changes.
// - Each command's answer returns in the following message.
`timescale 1ns/1ps
`default_nettype none
module gdl_core import gdl_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic phase_a_low_side_input,
   input wire logic phase_b_low_side_input,
   input wire logic phase_c_low_side_input,
   input wire logic phase_a_high_side_input_n,
   input wire logic phase_b_high_side_input_n,
   input wire logic phase_c_high_side_input_n,
   input wire logic enable_pin_one,
   input wire logic enable_pin_two,
   input wire logic run_pin,
   input wire logic pump_strap,
   input wire logic shutdown_fault,
   input wire logic [GDL_NEV-1:0] fault_event,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic [7:0] dt_cal_value,
   output logic [GDL_NPH-1:0] high_side_gate_out,
   output logic [GDL_NPH-1:0] low_side_gate_out,
   output logic [GDL_NPH-1:0] high_side_short_out,
   output logic charge_pump_en,
   output logic interrupt_out,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic [2:0] mode_bits,
   output logic mode_locked,
   output logic [7:0] deadtime_out
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic cmd_is_mask(input logic [7:0] c);
      return c[7:5] == GDL_OP_MASK;
   endfunction : cmd_is_mask

   function automatic logic cmd_is_mode(input logic [7:0] c);
      return c[7:4] == GDL_OP_MODE;
   endfunction : cmd_is_mode

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   gdl_pins_s pins_raw;
   gdl_pins_s ps;
   logic [7:0] cmd;
   logic cmd_valid;
   logic [7:0] rsp;

   assign pins_raw.en1 = enable_pin_one;
   assign pins_raw.en2 = enable_pin_two;
   assign pins_raw.run_pin = run_pin;
   assign pins_raw.pump = pump_strap;
   assign pins_raw.shut = shutdown_fault;
   assign pins_raw.ev = fault_event;
   assign pins_raw.sck = spi_sck;
   assign pins_raw.cs_n = spi_cs_n;
   assign pins_raw.mosi = spi_mosi;
   // Merged drive simply shows both inputs moving together
   assign pins_raw.ph.ls = {phase_c_low_side_input,
                            phase_b_low_side_input,
                            phase_a_low_side_input};
   assign pins_raw.ph.hs_n = {phase_c_high_side_input_n,
                              phase_b_high_side_input_n,
                              phase_a_high_side_input_n};

   gdl_sync #(
      .W($bits(gdl_pins_s)),
      .RST_VAL(GDL_PINS_RST)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .raw_in(pins_raw),
      .filt_out(ps)
   );

   gdl_spi_slave u_spi (
      .clk(clk),
      .rst(rst),
      .sck(ps.sck),
      .cs_n(ps.cs_n),
      .mosi(ps.mosi),
      .rsp(rsp),
      .cmd(cmd),
      .cmd_valid(cmd_valid),
      .miso(spi_miso),
      .miso_oe(spi_miso_oe)
   );

   // ----------------------------------------------------------------
   // Core state
   // ----------------------------------------------------------------
   gdl_core_s c_reg;
   gdl_core_s c_next;
   logic normal;
   logic gate_ok;
   logic take_cmd;
   logic [GDL_NPH-1:0] ls_rise;
   logic [GDL_NPH-1:0] hs_fall;
   logic [GDL_NPH-1:0] hs_rise;

   localparam gdl_core_s GDL_CORE_RST = '{
      ph: '{GDL_NPH{GDL_PH_LOCKED}},
      flags: '0,
      mask: GDL_MASK_RST,
      mode: GDL_MODE_RST,
      locked: 1'b0,
      deadtime: GDL_DT_RST,
      powered: 1'b0,
      pump_on: 1'b0,
      irq: 1'b0,
      ls_prev: '0,
      hs_prev: '1,
      hs_gate: '0,
      ls_gate: '0,
      hs_short: '0};

   assign normal = ps.en1 & ps.en2;
   assign gate_ok = normal & ~ps.shut & c_reg.powered;
   assign take_cmd = cmd_valid & c_reg.powered;
   // Edges, so a held level never re-arms a phase
   assign ls_rise = ps.ph.ls & ~c_reg.ls_prev;
   assign hs_fall = ~ps.ph.hs_n & c_reg.hs_prev;
   assign hs_rise = ps.ph.hs_n & ~c_reg.hs_prev;

   // ----------------------------------------------------------------
   // Answer for the next message
   // ----------------------------------------------------------------
   always_comb begin
      rsp = {c_reg.flags, c_reg.mask};
      if (cmd == GDL_STATUS_QUERY_CMD_HIGH) begin
         rsp = {c_reg.locked, c_reg.mode, normal, c_reg.ph[2] == GDL_PH_RUN,
                c_reg.ph[1] == GDL_PH_RUN, c_reg.ph[0] == GDL_PH_RUN};
      end else if (cmd == GDL_STATUS_QUERY_CMD_DT) begin
         rsp = c_reg.deadtime;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [GDL_NEV-1:0] clr;
      logic hs_on;
      clr = '0;
      hs_on = 1'b0;
      c_next = c_reg;
      c_next.powered = 1'b1;
      c_next.ls_prev = ps.ph.ls;
      c_next.hs_prev = ps.ph.hs_n;
      // Strap caught on the first clock after release
      if (!c_reg.powered) begin
         c_next.pump_on = ps.pump;
      end
      if (take_cmd) begin
         if (cmd_is_mask(cmd)) begin
            c_next.mask = cmd[3:0];
         end else if (cmd_is_mode(cmd) && !c_reg.locked) begin
            c_next.mode = cmd[3:1];
            c_next.locked = cmd[0];
         end else if (cmd == GDL_CLEAR_IRQ_CMD_LOW) begin
            clr = GDL_CLR_LOW_BITS;
         end else if (cmd == GDL_CLEAR_IRQ_CMD_HIGH) begin
            clr = GDL_CLR_HIGH_BITS;
         end else if (cmd == GDL_DT_ZERO_CMD) begin
            c_next.deadtime = '0;
         end else if (cmd == GDL_DT_CAL_CMD) begin
            c_next.deadtime = dt_cal_value;
         end
      end
      // New event beats a clear in the same cycle
      c_next.flags = (c_reg.flags & ~clr) | (ps.ev & {GDL_NEV{c_reg.powered}});
      for (int i = 0; i < GDL_NPH; i++) begin
         if (!gate_ok) begin
            c_next.ph[i] = GDL_PH_LOCKED;
         end else begin
            case (c_reg.ph[i])
               GDL_PH_LOCKED: begin
                  if (ls_rise[i]) begin
                     c_next.ph[i] = GDL_PH_ARMED;
                  end
               end
               GDL_PH_ARMED: begin
                  if (hs_fall[i]) begin
                     c_next.ph[i] = GDL_PH_PULSE;
                  end
               end
               GDL_PH_PULSE: begin
                  if (hs_rise[i]) begin
                     c_next.ph[i] = GDL_PH_RUN;
                  end
               end
               GDL_PH_RUN: begin
                  c_next.ph[i] = GDL_PH_RUN;
               end
               default: begin
                  c_next.ph[i] = GDL_PH_LOCKED;
               end
            endcase
         end
         // Pulse state drives the high side on: recirculation
         hs_on = gate_ok & ~ps.ph.hs_n[i] &
                 ((c_next.ph[i] == GDL_PH_PULSE) |
                  ((c_next.ph[i] == GDL_PH_RUN) & ~ps.ph.ls[i]));
         c_next.hs_gate[i] = hs_on;
         // High side lockout of the low side prevents shoot-through
         c_next.ls_gate[i] = gate_ok & ps.ph.ls[i] & ~hs_on;
         c_next.hs_short[i] = (c_next.ph[i] == GDL_PH_RUN) & ~hs_on;
      end
      c_next.irq = |(c_next.flags & ~c_next.mask);
      if (!ps.run_pin) begin
         c_next = GDL_CORE_RST;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         c_reg <= GDL_CORE_RST;
      end else begin
         c_reg <= c_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign high_side_gate_out = c_reg.hs_gate;
   assign low_side_gate_out = c_reg.ls_gate;
   assign high_side_short_out = c_reg.hs_short;
   assign charge_pump_en = c_reg.pump_on;
   assign interrupt_out = c_reg.irq;
   assign mode_bits = c_reg.mode;
   assign mode_locked = c_reg.locked;
   assign deadtime_out = c_reg.deadtime;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   gates_low_stby_a: assert property (
      (!normal || ps.shut) |=> (high_side_gate_out == '0 &&
                                low_side_gate_out == '0 &&
                                c_reg.ph[0] == GDL_PH_LOCKED))
      else $error("gates not low or phase not locked in standby");

   ls_needs_norm_a: assert property (
      low_side_gate_out[0] |-> $past(normal))
      else $error("low side on without both enables");

   arm_on_ls_a: assert property (
      (c_reg.ph[0] == GDL_PH_LOCKED && gate_ok && ls_rise[0] &&
       ps.run_pin) |=> c_reg.ph[0] == GDL_PH_ARMED)
      else $error("low side edge did not arm phase a");

   lock_held_a: assert property (
      (c_reg.ph[0] == GDL_PH_LOCKED && !ls_rise[0]) |=>
      (c_reg.ph[0] == GDL_PH_LOCKED && !high_side_gate_out[0]))
      else $error("phase a left lockout without low side edge");

   recirc_a: assert property (
      (c_reg.ph[0] == GDL_PH_ARMED && gate_ok && hs_fall[0] &&
       ps.run_pin) |=> (c_reg.ph[0] == GDL_PH_PULSE &&
                        high_side_gate_out[0] && !low_side_gate_out[0]))
      else $error("high side pulse did not turn high side on");

   short_after_a: assert property (
      (c_reg.ph[0] == GDL_PH_PULSE && gate_ok && hs_rise[0] &&
       ps.run_pin) |=> (high_side_short_out[0] && !high_side_gate_out[0]))
      else $error("gate not shorted after high side toggle");

   mask_cmd_a: assert property (
      (take_cmd && cmd_is_mask(cmd) && ps.run_pin) |=>
      c_reg.mask == $past(cmd[3:0]))
      else $error("mask command not applied");

   mode_lock_a: assert property (
      (c_reg.locked && ps.run_pin) |=>
      (c_reg.locked && $stable(c_reg.mode)))
      else $error("mode changed after lock");

   irq_out_a: assert property (
      (ps.ev[1] && !c_reg.mask[1] && c_reg.powered && ps.run_pin &&
       !take_cmd) |=>
      interrupt_out ##1 (interrupt_out || !ps.run_pin ||
                         $past(cmd_valid)))
      else $error("unmasked event did not raise interrupt");

   pump_off_a: assert property (
      !ps.run_pin |=> (!charge_pump_en && !c_reg.powered))
      else $error("charge pump on while held in reset");

   phase_run_c: cover property (
      c_reg.ph[0] == GDL_PH_PULSE ##[1:300] c_reg.ph[0] == GDL_PH_RUN);

   lock_cmd_c: cover property (
      !c_reg.locked ##1 c_reg.locked);

   irq_clear_c: cover property (
      interrupt_out ##[1:300] !interrupt_out);

endmodule : gdl_core
`default_nettype wire

// [test/gdl_host_model.sv]
/*
 Host controller model: phase, enable and SPI pins of the core.
 Assumes clk is the core clock; all pins change after its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module gdl_host_model import gdl_pkg::*; (
   input wire logic clk,
   input wire logic miso,
   output var gdl_phase_in_s ph,
   output logic en1,
   output logic en2,
   output logic sck,
   output logic cs_n,
   output logic mosi
);
   initial begin
      ph = '{ls: 3'h0, hs_n: 3'h7};
      {en1, en2, sck, cs_n, mosi} = 5'h02;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic drive(input logic [2:0] l, input logic [2:0] h,
                        input int n);
      ph <= '{ls: l, hs_n: h};
      tick(n);
   endtask : drive

   // Eight clocks a level keeps clear of the pin filter latency
   task automatic spi(input logic [7:0] c, output logic [7:0] r);
      cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi <= c[i];
         tick(8);
         sck <= 1'b1;
         r[i] = miso;
         tick(8);
         sck <= 1'b0;
      end
      tick(8);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      tick(16);
   endtask : spi

   task automatic enables(input logic e);
      en1 <= e;
      en2 <= e;
   endtask : enables

   // Stops with high side inputs low; caller ends the pulse
   task automatic init(input logic m);
      enables(1'b1);
      tick(20);
      drive(3'h7, 3'h7, 50);
      drive(3'h0, m ? 3'h0 : 3'h7, 4);
      drive(3'h0, 3'h0, 10);
   endtask : init
endmodule : gdl_host_model
`default_nettype wire

// [test/gate_drive_init_lockout_tb.sv]
/*
 Self-checking bench for the gate drive lockout core.
 Assumes gdl_host_model plays the controller on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module gate_drive_init_lockout_tb import gdl_pkg::*;;
   logic clk, rst, run_pin, pump, shut;
   logic [3:0] ev;
   logic [7:0] dtc, r;
   logic [2:0] hs, ls, sh, mode;
   logic pump_en, irq, miso, locked, oe;
   logic [7:0] dt;
   gdl_phase_in_s ph;
   logic en1, en2, sck, cs_n, mosi;
   int mismatches = 0, compares = 0, cyc = 0;

   gdl_host_model u_host (.clk(clk), .miso(miso), .ph(ph), .en1(en1),
      .en2(en2), .sck(sck), .cs_n(cs_n), .mosi(mosi));
   gdl_core u_dut (.clk(clk), .rst(rst),
      .phase_a_low_side_input(ph.ls[0]), .phase_b_low_side_input(ph.ls[1]),
      .phase_c_low_side_input(ph.ls[2]),
      .phase_a_high_side_input_n(ph.hs_n[0]),
      .phase_b_high_side_input_n(ph.hs_n[1]),
      .phase_c_high_side_input_n(ph.hs_n[2]),
      .enable_pin_one(en1), .enable_pin_two(en2), .run_pin(run_pin),
      .pump_strap(pump), .shutdown_fault(shut), .fault_event(ev),
      .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .dt_cal_value(dtc),
      .high_side_gate_out(hs), .low_side_gate_out(ls),
      .high_side_short_out(sh), .charge_pump_en(pump_en),
      .interrupt_out(irq), .spi_miso(miso), .spi_miso_oe(oe),
      .mode_bits(mode), .mode_locked(locked), .deadtime_out(dt));

   // ----------------------------------------------------------------
   // Clock, timeout, checking
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_setup;
      chk({hs, ls, irq, pump_en}, 8'h00);
      chk(oe, 1'b0);
      run_pin <= 1'b1;
      pump <= 1'b1;
      u_host.tick(10);
      chk(pump_en, 1'b1);
      u_host.spi(GDL_CLEAR_IRQ_CMD_LOW, r);
      u_host.spi(GDL_CLEAR_IRQ_CMD_HIGH, r);
      u_host.spi(8'h25, r);
      u_host.spi(8'h81, r);
      chk(dt, 8'h5A);
      u_host.spi(8'h80, r);
      chk(dt, 8'h00);
      dtc <= 8'hC3;
      u_host.spi(8'h81, r);
      chk(dt, 8'hC3);
      u_host.spi(8'h43, r);
      u_host.spi(8'h4C, r);
      chk({locked, mode}, 4'h9);
      u_host.spi(8'h00, r);
      u_host.spi(8'h02, r);
      chk(r, 8'h05);
      u_host.spi(8'h01, r);
      chk(r, 8'hC3);
      u_host.spi(8'h00, r);
      chk(r, 8'h90);
   endtask : t_setup

   // Mask 0101 hides events 0 and 2
   task automatic t_irq;
      ev <= 4'h4;
      u_host.tick(10);
      ev <= 4'h0;
      u_host.tick(10);
      chk(irq, 1'b0);
      ev <= 4'h2;
      u_host.tick(10);
      ev <= 4'h0;
      u_host.tick(10);
      chk(irq, 1'b1);
      u_host.spi(8'h60, r);
      chk(irq, 1'b0);
   endtask : t_irq

   // Low side edge before the enables must not arm anything
   task automatic t_early;
      u_host.drive(3'h7, 3'h7, 10);
      chk({hs, ls}, 6'h00);
      u_host.drive(3'h0, 3'h7, 10);
   endtask : t_early

   task automatic t_init;
      u_host.init(1'b0);
      chk({hs, ls}, 6'h38);
      u_host.drive(3'h0, 3'h7, 10);
      chk({hs, sh}, 6'h07);
      u_host.drive(3'h0, 3'h6, 10);
      chk(hs, 3'h1);
      u_host.drive(3'h1, 3'h7, 10);
      chk({hs, ls}, 6'h01);
   endtask : t_init

   task automatic t_fault;
      shut <= 1'b1;
      u_host.tick(10);
      chk({hs, ls}, 6'h00);
      shut <= 1'b0;
      u_host.drive(3'h0, 3'h7, 10);
      u_host.drive(3'h0, 3'h0, 10);
      chk(hs, 3'h0);
      u_host.init(1'b1);
      chk(hs, 3'h7);
      u_host.drive(3'h7, 3'h7, 10);
      chk({hs, sh}, 6'h07);
      chk(ls, 3'h7);
      u_host.enables(1'b0);
      u_host.tick(10);
      chk({hs, ls}, 6'h00);
   endtask : t_fault

   // Run pin drop acts as a mid-run core reset
   task automatic t_rerun;
      run_pin <= 1'b0;
      u_host.tick(10);
      chk({pump_en, locked, mode}, 5'h00);
      run_pin <= 1'b1;
      pump <= 1'b0;
      u_host.tick(10);
      chk(pump_en, 1'b0);
      chk(dt, 8'h00);
   endtask : t_rerun

   initial begin
      rst = 1'b1;
      run_pin = 1'b0;
      pump = 1'b0;
      shut = 1'b0;
      ev = 4'h0;
      dtc = 8'h5A;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_setup();
      t_irq();
      t_early();
      t_init();
      t_fault();
      t_rerun();
      give_verdict();
   end
endmodule : gate_drive_init_lockout_tb
`default_nettype wire
